// File: rtl/spf_flash_end.sv
// Flash-side command logic: status lock, power-down entry, resume with ID.
// Assumes mode 0 or 3 link, clock stopped while select is high.
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "spf_params.svh"
module spf_flash_end
  import spf_pkg::*;
#(
  parameter logic [7:0] DEV_ID = `SPF_DEV_ID
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  spf_link_if.dev_mp link,
  input wire logic self_timed_busy_flag_in,
  input wire logic power_down_mode_select_in,
  input wire logic status_protect_high_bit_in,
  input wire logic status_protect_low_bit_in,
  input wire logic write_enable_latch_in,
  output logic status_locked_out,
  output logic deep_power_down_state_out,
  output logic ultra_deep_sleep_state_out,
  output logic wel_clear_out,
  output logic init_start_out,
  output logic reset_out,
  output logic abort_out,
  output logic ignored_out,
  output logic cmd_valid_out,
  output logic [7:0] cmd_out
);

  // Link domain
  logic in_frame_r;
  logic [2:0] bit_idx_r;
  logic [2:0] byte_cnt_r;
  logic [6:0] shift_r;
  logic [7:0] cmd_r;
  logic [7:0] vb1_r;
  logic [7:0] vb2_r;
  logic [1:0] ultra_sync_r;
  logic [2:0] idx_cur;
  logic [2:0] cnt_cur;
  logic [7:0] byte_now;
  logic id_on;

  // Core domain
  logic [2:0] cs_sync_r;
  logic cs_filt_r;
  logic [1:0] inf_sync_r;
  logic clocked_r;
  spf_pwr_type pwr_r;
  logic armed_r;
  logic locked_r;
  logic frame_end;
  logic done;
  logic whole;
  logic standby;
  logic lock_go;
  logic lock_end;
  logic pd_go;
  logic resume_go;
  logic rst_en_go;
  logic rst_go;
  logic own_cmd;
  logic sr_write;
  logic fwd_go;
  logic drop_go;

  // Cleared by the frame's own select so no stale frame survives
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      in_frame_r <= 1'b0;
    end else begin
      in_frame_r <= 1'b1;
    end
  end

  assign idx_cur = in_frame_r ? bit_idx_r : 3'h0;
  assign cnt_cur = in_frame_r ? byte_cnt_r : 3'h0;
  assign byte_now = {shift_r, link.si};

  always_ff @(posedge link.sclk) begin
    shift_r <= byte_now[6:0];
    bit_idx_r <= 3'(idx_cur + 3'h1);
    if (idx_cur == 3'h7) begin
      case (cnt_cur)
        3'h0: cmd_r <= byte_now;
        3'h1: vb1_r <= byte_now;
        3'h2: vb2_r <= byte_now;
        default: ;
      endcase
      byte_cnt_r <= (cnt_cur == 3'h7) ? cnt_cur : 3'(cnt_cur + 3'h1);
    end else begin
      byte_cnt_r <= cnt_cur;
    end
  end

  always_ff @(posedge link.sclk) begin
    ultra_sync_r <= {ultra_sync_r[0], pwr_r == SPF_PWR_ULTRA};
  end

  // ID only after command plus three dummy bytes
  // no ID while in the ultra state
  assign id_on = in_frame_r && (cmd_r == SPF_CMD_RESUME) && (byte_cnt_r >= `SPF_ID_START_BYTES) && !ultra_sync_r[1];
  // ID repeats, MSB first, each byte
  assign link.so = id_on ? DEV_ID[~bit_idx_r] : 1'b0;

  // Select passes three flops; a change counts when the last two agree
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      cs_sync_r <= 3'h7;
      cs_filt_r <= 1'b1;
    end else begin
      cs_sync_r <= {cs_sync_r[1:0], link.cs_n};
      if (cs_sync_r[1] == cs_sync_r[2]) begin
        cs_filt_r <= cs_sync_r[2];
      end
    end
  end

  // Frame seen clocking; frames of one or two edges may be missed, but those are never whole
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      inf_sync_r <= 2'h0;
      clocked_r <= 1'b0;
    end else begin
      inf_sync_r <= {inf_sync_r[0], in_frame_r};
      if (frame_end) begin
        clocked_r <= 1'b0;
      end else if (inf_sync_r[1]) begin
        clocked_r <= 1'b1;
      end
    end
  end

  // Link words are read here and by the output flops at frame end: the link clock stands still while select is high
  always_comb begin
    frame_end = !cs_filt_r && cs_sync_r[1] && cs_sync_r[2];
    done = frame_end && (clocked_r || inf_sync_r[1]);
    standby = (pwr_r == SPF_PWR_STANDBY);
    whole = done && (bit_idx_r == 3'h0) && (byte_cnt_r != 3'h0);
    lock_go = whole && standby && (cmd_r == SPF_CMD_LOCK) && (byte_cnt_r == `SPF_LOCK_BYTES) &&
              (vb1_r == `SPF_VERIFY_BYTE1) && (vb2_r == `SPF_VERIFY_BYTE2) && write_enable_latch_in &&
              ({status_protect_high_bit_in, status_protect_low_bit_in} == `SPF_PROTECT_LOCK);
    lock_end = done && standby && (byte_cnt_r != 3'h0) && (cmd_r == SPF_CMD_LOCK);
    pd_go = whole && standby && (cmd_r == SPF_CMD_PD) && !self_timed_busy_flag_in;
    resume_go = whole && (cmd_r == SPF_CMD_RESUME);
    // reset pair accepted in deep state
    rst_en_go = whole && (pwr_r != SPF_PWR_ULTRA) && (cmd_r == SPF_CMD_RST_EN);
    rst_go = whole && (pwr_r != SPF_PWR_ULTRA) && (cmd_r == SPF_CMD_RST) && armed_r;
    own_cmd = (cmd_r == SPF_CMD_LOCK) || (cmd_r == SPF_CMD_PD) || (cmd_r == SPF_CMD_RESUME) ||
              (cmd_r == SPF_CMD_RST_EN) || (cmd_r == SPF_CMD_RST);
    sr_write = (cmd_r == SPF_CMD_WRSR1) || (cmd_r == SPF_CMD_WRSR2) || (cmd_r == SPF_CMD_WRSR3) ||
               (cmd_r == SPF_CMD_WRSR_IND);
    // everything else ignored while powered down
    fwd_go = whole && standby && !own_cmd && !(locked_r && sr_write);
    drop_go = whole && !own_cmd && !fwd_go;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      pwr_r <= SPF_PWR_STANDBY;
    end else begin
      case (pwr_r)
        SPF_PWR_STANDBY: begin
          if (pd_go) begin
            pwr_r <= power_down_mode_select_in ? SPF_PWR_DEEP : SPF_PWR_ULTRA;
          end
        end
        SPF_PWR_DEEP: begin
          if (resume_go || rst_go) begin
            pwr_r <= SPF_PWR_STANDBY;
          end
        end
        SPF_PWR_ULTRA: begin
          if (resume_go) begin
            pwr_r <= SPF_PWR_STANDBY;
          end
        end
        default: pwr_r <= SPF_PWR_STANDBY;
      endcase
    end
  end

  // Any frame other than enable-reset disarms the reset pair
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      armed_r <= 1'b0;
    end else if (done) begin
      armed_r <= rst_en_go;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      locked_r <= 1'b0;
    end else if (lock_go) begin
      locked_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      wel_clear_out <= 1'b0;
      init_start_out <= 1'b0;
      reset_out <= 1'b0;
      abort_out <= 1'b0;
      ignored_out <= 1'b0;
      cmd_valid_out <= 1'b0;
      cmd_out <= 8'h00;
    end else begin
      wel_clear_out <= lock_end;
      init_start_out <= resume_go && (pwr_r == SPF_PWR_ULTRA);
      reset_out <= rst_go;
      abort_out <= done && (bit_idx_r != 3'h0);
      ignored_out <= drop_go || (whole && own_cmd && !lock_go && !pd_go && !resume_go && !rst_en_go && !rst_go);
      cmd_valid_out <= fwd_go;
      if (fwd_go) begin
        cmd_out <= cmd_r;
      end
    end
  end

  assign status_locked_out = locked_r;
  assign deep_power_down_state_out = (pwr_r == SPF_PWR_DEEP);
  assign ultra_deep_sleep_state_out = (pwr_r == SPF_PWR_ULTRA);

endmodule
`default_nettype wire

// File: shared/spf_params.svh
// Constants shared by both ends of the serial flash command link.
// Included by bare name; holds definitions only.
`ifndef SPF_PARAMS_SVH
`define SPF_PARAMS_SVH

// Lock verification bytes and protect-bit pattern
`define SPF_VERIFY_BYTE1 8'h4d
`define SPF_VERIFY_BYTE2 8'h67
`define SPF_PROTECT_LOCK 2'b11

// Byte counts: complete lock frame, and bytes before the ID starts
`define SPF_LOCK_BYTES 3'h3
`define SPF_ID_START_BYTES 3'h4

// Identity byte returned by resume; value is arbitrary
`define SPF_DEV_ID 8'h5a

// Host register byte offsets
`define SPF_REG_CMD 8'h00
`define SPF_REG_DATA 8'h04
`define SPF_REG_STAT 8'h08

// Host field positions
`define SPF_CMD_LEN_LSB 8
`define SPF_CMD_LEN_MSB 10
`define SPF_STAT_RX_LSB 8

// Host timing counts in system clocks
`define SPF_HALF_DIV 8
`define SPF_CS_GAP 16

`endif

// File: shared/spf_pkg.sv
// Types shared by both ends of the serial flash command link.
// Assumes nothing of its surroundings.
`default_nettype none
package spf_pkg;

  typedef enum logic [7:0] {
    SPF_CMD_WRSR1 = 8'h01,
    SPF_CMD_WREN = 8'h06,
    SPF_CMD_WRSR3 = 8'h11,
    SPF_CMD_WRSR2 = 8'h31,
    SPF_CMD_RST_EN = 8'h66,
    SPF_CMD_LOCK = 8'h6f,
    SPF_CMD_WRSR_IND = 8'h71,
    SPF_CMD_RST = 8'h99,
    SPF_CMD_RESUME = 8'hab,
    SPF_CMD_PD = 8'hb9
  } spf_cmd_type;

  typedef enum logic [1:0] {
    SPF_PWR_STANDBY = 2'b00,
    SPF_PWR_DEEP = 2'b01,
    SPF_PWR_ULTRA = 2'b10
  } spf_pwr_type;

  typedef enum logic [1:0] {
    SPF_HST_IDLE = 2'b00,
    SPF_HST_RUN = 2'b01,
    SPF_HST_GAP = 2'b10
  } spf_hstate_type;

endpackage
`default_nettype wire

// File: shared/spf_link_if.sv
// Serial link between host controller and flash end: select, clock, in, out.
// Host drives select, clock and serial in; flash end drives serial out.
`timescale 1ns/100ps
`default_nettype none
interface spf_link_if;
  logic cs_n;
  logic sclk;
  logic si;
  logic so;

  modport host_mp (
    output cs_n,
    output sclk,
    output si,
    input so
  );

  modport dev_mp (
    input cs_n,
    input sclk,
    input si,
    output so
  );
endinterface
`default_nettype wire

// File: rtl/spf_host_end.sv
// Host controller: AHB-Lite register slave that runs one link frame per order.
// Assumes one AHB master, single word transfers; link clock made here by a divider.
`timescale 1ns/100ps
`default_nettype none
`include "spf_params.svh"
module spf_host_end
  import spf_pkg::*;
#(
  parameter int unsigned HALF_DIV = `SPF_HALF_DIV,
  parameter int unsigned CS_GAP = `SPF_CS_GAP
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  spf_link_if.host_mp link
);

  spf_hstate_type st_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic [23:0] data_r;
  logic cs_n_r;
  logic sclk_r;
  logic si_r;
  logic [7:0] div_r;
  logic [5:0] bits_r;
  logic [31:0] tx_r;
  logic [7:0] rx_r;
  logic [2:0] so_sync_r;
  logic so_filt_r;
  logic ap_take;
  logic start;
  logic [2:0] len;

  // whole frames only, no cut-short option
  assign len = hwdata_in[`SPF_CMD_LEN_MSB:`SPF_CMD_LEN_LSB];
  assign ap_take = hsel_in && htrans_in[1] && hready_in;
  assign start = wr_pend_r && (wr_addr_r == `SPF_REG_CMD) && (st_r == SPF_HST_IDLE) && (len != 3'h0);

  // Zero wait states; reads answered from a flop in the data phase
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
    end else begin
      wr_pend_r <= ap_take && hwrite_in;
      if (ap_take) begin
        wr_addr_r <= haddr_in[7:0];
      end
      if (ap_take && !hwrite_in) begin
        case (haddr_in[7:0])
          `SPF_REG_DATA: hrdata_r <= {8'h00, data_r};
          `SPF_REG_STAT: hrdata_r <= {16'h0000, rx_r, 7'h00, st_r != SPF_HST_IDLE};
          default: hrdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      data_r <= 24'h00_0000;
    end else if (wr_pend_r && (wr_addr_r == `SPF_REG_DATA)) begin
      data_r <= hwdata_in[23:0];
    end
  end

  // Serial out from the far end passes three flops, last two must agree
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      so_sync_r <= 3'h0;
      so_filt_r <= 1'b0;
    end else begin
      so_sync_r <= {so_sync_r[1:0], link.so};
      if (so_sync_r[1] == so_sync_r[2]) begin
        so_filt_r <= so_sync_r[2];
      end
    end
  end

  // Mode 0 master: so is sampled as sclk rises; the far end moves so on that same rise, so the filter delay fits inside one sclk period
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      st_r <= SPF_HST_IDLE;
      cs_n_r <= 1'b1;
      sclk_r <= 1'b0;
      si_r <= 1'b0;
      div_r <= 8'h00;
      bits_r <= 6'h00;
      tx_r <= 32'h0000_0000;
      rx_r <= 8'h00;
    end else begin
      case (st_r)
        SPF_HST_IDLE: begin
          if (start) begin
            cs_n_r <= 1'b0;
            si_r <= hwdata_in[7];
            tx_r <= {hwdata_in[7:0], data_r[7:0], data_r[15:8], data_r[23:16]};
            bits_r <= {len, 3'h0};
            div_r <= 8'h00;
            st_r <= SPF_HST_RUN;
          end
        end
        SPF_HST_RUN: begin
          if (div_r == 8'(HALF_DIV - 1)) begin
            div_r <= 8'h00;
            if (!sclk_r) begin
              sclk_r <= 1'b1;
              rx_r <= {rx_r[6:0], so_filt_r};
            end else begin
              sclk_r <= 1'b0;
              tx_r <= {tx_r[30:0], 1'b0};
              si_r <= tx_r[30];
              bits_r <= 6'(bits_r - 6'h1);
              // select rises right after last clock
              if (bits_r == 6'h1) begin
                cs_n_r <= 1'b1;
                si_r <= 1'b0;
                st_r <= SPF_HST_GAP;
              end
            end
          end else begin
            div_r <= 8'(div_r + 8'h1);
          end
        end
        SPF_HST_GAP: begin
          if (div_r == 8'(CS_GAP - 1)) begin
            div_r <= 8'h00;
            st_r <= SPF_HST_IDLE;
          end else begin
            div_r <= 8'(div_r + 8'h1);
          end
        end
        default: st_r <= SPF_HST_IDLE;
      endcase
    end
  end

  assign link.cs_n = cs_n_r;
  assign link.sclk = sclk_r;
  assign link.si = si_r;
  assign hrdata_out = hrdata_r;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

endmodule
`default_nettype wire

// File: dv/spf_link_asserts.sv
// Checker on the serial link between the host and flash ends.
// Assumes default divider (8) and gap (16) counts; sees link pins only.
`timescale 1ns/100ps
`default_nettype none
module spf_link_asserts (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic so
);
  localparam int GAP_MIN = 16;
  logic sclk_q_r;
  logic [7:0] edge_cnt_r;
  logic [7:0] gap_cnt_r;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  always_ff @(posedge sys_clk_in) begin
    sclk_q_r <= rstn_in & sclk;
  end
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || cs_n) begin
      edge_cnt_r <= 8'h00;
    end else if (sclk && !sclk_q_r && edge_cnt_r != 8'hff) begin
      edge_cnt_r <= edge_cnt_r + 8'h01;
    end
  end
  // Saturates so long idle spans never wrap below the minimum
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      gap_cnt_r <= 8'(GAP_MIN);
    end else if (!cs_n) begin
      gap_cnt_r <= 8'h00;
    end else if (gap_cnt_r != 8'hff) begin
      gap_cnt_r <= gap_cnt_r + 8'h01;
    end
  end
  sequence lead_in_s;
    !sclk [*8] ##1 sclk;
  endsequence
  sequence high_phase_s;
    sclk [*8] ##1 !sclk;
  endsequence
  AST_SO_QUIET: assert property (cs_n |-> !so) else $error("so driven while deselected");
  AST_SCLK_PARK: assert property (cs_n |-> !sclk) else $error("link clock not parked low");
  AST_SI_HOLD: assert property (sclk && sclk_q_r |-> $stable(si)) else $error("si moved in high phase");
  AST_LEAD_IN: assert property ($fell(cs_n) |-> lead_in_s) else $error("first clock edge misplaced");
  AST_HALF_HIGH: assert property ($rose(sclk) |-> high_phase_s) else $error("high phase length wrong");
  AST_BYTE_END: assert property ($rose(cs_n) |-> edge_cnt_r != 8'h00 && edge_cnt_r[2:0] == 3'h0)
    else $error("frame ended off a byte boundary");
  AST_FRAME_GAP: assert property ($fell(cs_n) |-> gap_cnt_r >= 8'(GAP_MIN)) else $error("frame gap too short");
  AST_ID_LATE: assert property (so |-> edge_cnt_r >= 8'h1f) else $error("so active before dummy bytes");
  cover property ($rose(so));
endmodule
`default_nettype wire

// File: dv/spi_flash_power_down_and_sr_lock_tb_top.sv
// Bench: host end drives flash end over AHB orders; a second link is bit-banged.
// Assumes default host counts and a reference model of the flash decode.
`timescale 1ns/100ps
`default_nettype none
`include "spf_params.svh"
module spi_flash_power_down_and_sr_lock_tb_top;
  import spf_pkg::*;
  logic clk, rstn, hsel, hwrite, hrdy, hresp, busy, mode, p1, p0, write_enable_latch;
  logic lkd, dp, ud, wc, ini, rs, ab, ig, cv, dp2, ab2;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] co;
  logic [5:0] pv;
  logic [31:0] haddr, hwdata, hrdata, rd, rv;
  int fail_count, checked, pwr, pc[6], pc2;
  bit locked, last66;
  spf_link_if lk();
  spf_link_if lk2();
  spf_host_end u_spf_host_end (.sys_clk_in(clk), .rstn_in(rstn), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hready_in(hrdy), .hwdata_in(hwdata),
    .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp), .link(lk.host_mp));
  spf_flash_end u_spf_flash_end (.sys_clk_in(clk), .rstn_in(rstn), .link(lk.dev_mp), .self_timed_busy_flag_in(busy),
    .power_down_mode_select_in(mode), .status_protect_high_bit_in(p1), .status_protect_low_bit_in(p0),
    .write_enable_latch_in(write_enable_latch), .status_locked_out(lkd), .deep_power_down_state_out(dp),
    .ultra_deep_sleep_state_out(ud), .wel_clear_out(wc), .init_start_out(ini), .reset_out(rs),
    .abort_out(ab), .ignored_out(ig), .cmd_valid_out(cv), .cmd_out(co));
  spf_flash_end u_spf_flash_end2 (.sys_clk_in(clk), .rstn_in(rstn), .link(lk2.dev_mp), .self_timed_busy_flag_in(busy),
    .power_down_mode_select_in(mode), .status_protect_high_bit_in(p1), .status_protect_low_bit_in(p0),
    .write_enable_latch_in(write_enable_latch), .status_locked_out(), .deep_power_down_state_out(dp2),
    .ultra_deep_sleep_state_out(), .wel_clear_out(), .init_start_out(), .reset_out(), .abort_out(ab2),
    .ignored_out(), .cmd_valid_out(), .cmd_out());
  spf_link_asserts u_spf_link_asserts (.sys_clk_in(clk), .rstn_in(rstn), .cs_n(lk.cs_n), .sclk(lk.sclk),
    .si(lk.si), .so(lk.so));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  assign pv = {wc, ini, rs, ab, ig, cv};
  // Pulses last one cycle, so they are tallied as they pass
  always @(posedge clk) begin
    foreach (pc[i]) if (pv[5 - i] === 1'b1) pc[i]++;
    if (ab2 === 1'b1) pc2++;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask
  // Link clock made here at 125 ns; stopped outside the frame
  task automatic bang(input logic [7:0] c, input int nb);
    lk2.cs_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      lk2.si = c[7 - i % 8];
      #62.5 lk2.sclk = 1'b1;
      #62.5 lk2.sclk = 1'b0;
    end
    #62.5 lk2.cs_n = 1'b1;
    lk2.si = ~lk2.si;
    #500;
  endtask
  // ct packs busy, mode, protect high, protect low, write latch
  task automatic run(input logic [7:0] c, input logic [2:0] n, input logic [7:0] b1, input logic [7:0] b2,
    input logic [4:0] ct);
    logic [31:0] r;
    logic [7:0] eid;
    int k, b[6], e[6];
    @(posedge clk);
    {busy, mode, p1, p0, write_enable_latch} <= ct;
    ahb(1'b1, `SPF_REG_DATA, {16'h0000, b2, b1}, r);
    ahb(1'b1, `SPF_REG_CMD, {21'h000000, n, c}, r);
    b = pc;
    k = 0;
    r = 32'h00000001;
    while (r[0] !== 1'b0 && k < 1000) begin
      ahb(1'b0, `SPF_REG_STAT, 32'h00000000, r);
      k++;
    end
    e = '{default: 0};
    eid = (c == 8'hab && n >= 3'h5 && pwr != 2) ? `SPF_DEV_ID : 8'h00;
    if (pwr == 0) begin
      if (c == 8'h6f) begin
        e[0] = 1;
        e[4] = !(n == 3'h3 && b1 == 8'h4d && b2 == 8'h67 && ct[0] && ct[2:1] == 2'b11);
        if (e[4] == 0) locked = 1;
      end else if (c == 8'hb9) begin
        if (ct[4]) e[4] = 1;
        else pwr = ct[3] ? 1 : 2;
      end else if (c == 8'h99) begin
        e[2] = last66;
        e[4] = !last66;
      end
      else if (locked && (c inside {8'h01, 8'h31, 8'h11, 8'h71})) e[4] = 1;
      else if (c != 8'hab && c != 8'h66) e[5] = 1;
    end else if (c == 8'hab) begin
      e[1] = (pwr == 2);
      pwr = 0;
    end else if (pwr == 1 && c == 8'h99 && last66) begin
      e[2] = 1;
      pwr = 0;
    end else if (!(pwr == 1 && c == 8'h66)) e[4] = 1;
    last66 = (c == 8'h66) && (pwr != 2);
    chk("busy", 8'h00, {7'h00, r[0]});
    chk("id", eid, r[15:8]);
    chk("deep", {7'h00, pwr == 1}, {7'h00, dp});
    chk("ultra", {7'h00, pwr == 2}, {7'h00, ud});
    chk("locked", {7'h00, locked}, {7'h00, lkd});
    for (int i = 0; i < 5; i++) chk($sformatf("pulse%0d", i), 8'(e[i]), 8'(pc[i] - b[i]));
    if (!(c inside {8'hab, 8'h66, 8'h99})) chk("fwd", 8'(e[5]), 8'(pc[5] - b[5]));
    if (e[5] == 1) chk("cmd", c, co);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #900us;
    fail_count++;
    end_of_test;
  end
  initial begin
    hsel = 1'b0; hwrite = 1'b0; htrans = 2'b00; hsize = 3'h2; haddr = 32'h0; hwdata = 32'h0;
    rstn = 1'b0;
    {busy, mode, p1, p0, write_enable_latch} = 5'h08;
    lk2.cs_n = 1'b1; lk2.sclk = 1'b0; lk2.si = 1'b0;
    void'($urandom(27650));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    bang(SPF_CMD_PD, 12);
    chk("abort2", 8'h01, 8'(pc2));
    chk("deep2", 8'h00, {7'h00, dp2});
    bang(SPF_CMD_PD, 8);
    chk("deep2", 8'h01, {7'h00, dp2});
    @(posedge clk);
    ahb(1'b0, 32'h0000000c, 32'h0, rd);
    chk("unmapped", 8'h00, rd[7:0]);
    chk("hresp", 8'h00, {7'h00, hresp});
    ahb(1'b1, `SPF_REG_CMD, 32'h00000006, rd);
    ahb(1'b0, `SPF_REG_STAT, 32'h0, rd);
    chk("len0", 8'h00, {7'h00, rd[0]});
    run(SPF_CMD_LOCK, 3'h3, 8'h4d, 8'h67, 5'h0e);
    run(SPF_CMD_LOCK, 3'h3, 8'h67, 8'h4d, 5'h0f);
    run(SPF_CMD_LOCK, 3'h3, 8'h4d, 8'h67, 5'h0d);
    run(SPF_CMD_LOCK, 3'h2, 8'h4d, 8'h67, 5'h0f);
    run(SPF_CMD_PD, 3'h1, 8'h00, 8'h00, 5'h18);
    run(SPF_CMD_RESUME, 3'h5, 8'h00, 8'h00, 5'h08);
    run(SPF_CMD_PD, 3'h1, 8'h00, 8'h00, 5'h08);
    run(8'h05, 3'h2, 8'h00, 8'h00, 5'h08);
    run(SPF_CMD_WREN, 3'h1, 8'h00, 8'h00, 5'h08);
    run(SPF_CMD_RESUME, 3'h1, 8'h00, 8'h00, 5'h08);
    run(SPF_CMD_PD, 3'h1, 8'h00, 8'h00, 5'h00);
    run(SPF_CMD_RST_EN, 3'h1, 8'h00, 8'h00, 5'h08);
    run(SPF_CMD_RESUME, 3'h5, 8'h00, 8'h00, 5'h08);
    run(SPF_CMD_PD, 3'h1, 8'h00, 8'h00, 5'h08);
    run(SPF_CMD_RESUME, 3'h6, 8'h00, 8'h00, 5'h08);
    run(SPF_CMD_PD, 3'h1, 8'h00, 8'h00, 5'h08);
    run(SPF_CMD_RST_EN, 3'h1, 8'h00, 8'h00, 5'h08);
    run(SPF_CMD_RST, 3'h1, 8'h00, 8'h00, 5'h08);
    run(SPF_CMD_LOCK, 3'h3, 8'h4d, 8'h67, 5'h0f);
    run(SPF_CMD_WRSR1, 3'h2, 8'h00, 8'h00, 5'h08);
    for (int i = 0; i < 6; i++) begin
      rv = $urandom;
      run(rv[1:0] == 2'b00 ? SPF_CMD_WREN : SPF_CMD_LOCK, {1'b0, rv[3:2]} + 3'h1, rv[4] ? 8'h4d : rv[15:8],
        rv[5] ? 8'h67 : rv[23:16], {2'b01, rv[7:6], rv[8]});
    end
    end_of_test;
  end
endmodule
`default_nettype wire
